// [include/flash_protect_pkg.sv]
// shared constants, types and helpers for the block write-protect logic
package flash_protect_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          BLOCK_BITS   = 10;
  localparam int          NUM_BLOCKS   = 1024;
  localparam int          WORD_W       = 16;
  localparam int          BOOT_AW      = 9;
  localparam int          BOOT_WORDS   = 512;
  localparam logic [8:0]  BOOT_LAST    = 9'h1ff;
  localparam logic [8:0]  BOOT_FIRST   = 9'h000;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_IDX      = 16'hf220;
  localparam logic [15:0] SBA_IDX      = 16'hf24c;
  localparam logic [15:0] WPS_IDX      = 16'hf24e;
  localparam logic [15:0] CTRL_IDX     = 16'hf250;
  localparam logic [6:0]  BOOT_IDX_HI  = 7'h00;
  localparam logic [13:0] ADR_HI_ZERO  = 14'h0000;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_UNLOCK     = 16'h0023;
  localparam logic [15:0] CMD_LOCK       = 16'h002a;
  localparam logic [15:0] CMD_LOCK_TIGHT = 16'h002c;
  localparam logic [15:0] CMD_HOT_RESET  = 16'h00f3;
  localparam logic [15:0] CMD_CORE_RESET = 16'h00f0;

  // ----------------------------------------------------------------
  // status codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  WPS_LOCKED   = 3'b010;
  localparam logic [2:0]  WPS_UNLOCKED = 3'b100;
  localparam logic [2:0]  WPS_TIGHT    = 3'b001;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [12:0] WPS_PAD      = 13'h0000;
  localparam logic [13:0] CTRL_PAD     = 14'h0000;
  localparam int          CTRL_DONE_BIT = 0;
  localparam int          CTRL_WERR_BIT = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PROT_LOCKED   = 2'b00,
    PROT_UNLOCKED = 2'b01,
    PROT_TIGHT    = 2'b10
  } prot_t;

  typedef enum logic [2:0] {
    BOOT_IDLE = 3'b001,
    BOOT_COPY = 3'b010,
    BOOT_DONE = 3'b100
  } boot_state_t;

  typedef struct packed {
    logic                  valid;
    logic [BLOCK_BITS-1:0] block;
  } op_req_t;

  typedef struct packed {
    logic               req;
    logic [BOOT_AW-1:0] addr;
  } boot_rd_req_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } boot_rd_rsp_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] wps_code(input prot_t s);
    case (s)
      PROT_UNLOCKED: wps_code = WPS_UNLOCKED;
      PROT_TIGHT:    wps_code = WPS_TIGHT;
      default:       wps_code = WPS_LOCKED;
    endcase
  endfunction

  function automatic prot_t next_prot(input prot_t s, input logic [15:0] cmd);
    next_prot = s;
    case (cmd)
      CMD_UNLOCK:     if (s == PROT_LOCKED) next_prot = PROT_UNLOCKED;
      CMD_LOCK:       if (s == PROT_UNLOCKED) next_prot = PROT_LOCKED;
      CMD_LOCK_TIGHT: if (s == PROT_LOCKED) next_prot = PROT_TIGHT;
      default:        next_prot = s;
    endcase
  endfunction

endpackage

// [rtl/flash_block_write_protect.sv]
// per-block write protection, boot copy and boot buffer lock behind wishbone
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - after power-up copy first 1KB of block 0 page 0 into boot buffer
// - once boot copy finishes, host writes to boot buffer are refused
// - cold or warm reset puts every block in the locked state
// - lock code at command register applies to block in start-block register
// - unlock releases only the addressed block; others keep their state
// - each block holds its own state: unlocked, locked or locked-tight
// - program and erase allowed on an unlocked block
// - program and erase refused on a locked block
// - lock command returns an unlocked block to locked
// - lock-tight only moves an already locked block to locked-tight
// - locked-tight block ignores lock and unlock commands
// - locked-tight leaves only by cold or warm reset, back to locked
// - status bits read 010 locked, 100 unlocked, 001 tight; reset 010
// - hot reset does not clear the three status bits
// - status refreshes on block number write and on protection command
// - hot reset clears command and start-block registers but keeps data and boot buffers
module flash_block_write_protect (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_hw_reset_pin_n,
  input  wire logic                          i_wb_cyc,
  input  wire logic                          i_wb_stb,
  input  wire logic                          i_wb_we,
  input  wire logic [31:0]                   i_wb_adr,
  input  wire logic [31:0]                   i_wb_dat,
  input  wire logic [3:0]                    i_wb_sel,
  output logic      [31:0]                   o_wb_dat,
  output logic                               o_wb_ack,
  input  wire flash_protect_pkg::op_req_t    i_op,
  output logic                               o_op_done,
  output logic                               o_op_allow,
  output flash_protect_pkg::boot_rd_req_t    o_boot_rd,
  input  wire flash_protect_pkg::boot_rd_rsp_t i_boot_rd,
  output logic                               o_boot_done
);
  import flash_protect_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  prot_t                 prot_q [NUM_BLOCKS];
  logic [WORD_W-1:0]     boot_mem [BOOT_WORDS];
  logic [15:0]           cmd_q;
  logic [15:0]           sba_q;
  logic [2:0]            wps_q;
  logic                  werr_q;
  logic                  ack_q;
  logic [31:0]           rdat_q;
  logic                  op_done_q;
  logic                  op_allow_q;
  boot_state_t           boot_q;
  logic [BOOT_AW-1:0]    boot_addr_q;
  logic                  pin_meta_q;
  logic                  pin_sync_q;

  // ----------------------------------------------------------------
  // warm reset pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // idle level of the pin, so cold reset is not followed by a false warm reset
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= i_hw_reset_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  logic warm;
  assign warm = ~pin_sync_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                  req;
  logic [15:0]           idx;
  logic                  hi_ok;
  logic                  wr_full;
  logic                  hit_cmd;
  logic                  hit_sba;
  logic                  hit_wps;
  logic                  hit_ctrl;
  logic                  hit_boot;
  logic                  cmd_go;
  logic                  wr_sba;
  logic                  wr_boot;
  logic [BLOCK_BITS-1:0] blk_sel;
  prot_t                 cur;
  prot_t                 nxt;

  assign req      = i_wb_cyc & i_wb_stb & ~ack_q;
  assign idx      = i_wb_adr[17:2];
  assign hi_ok    = (i_wb_adr[31:18] == ADR_HI_ZERO);
  assign wr_full  = req & i_wb_we & i_wb_sel[0] & i_wb_sel[1];
  assign hit_cmd  = hi_ok & (idx == CMD_IDX);
  assign hit_sba  = hi_ok & (idx == SBA_IDX);
  assign hit_wps  = hi_ok & (idx == WPS_IDX);
  assign hit_ctrl = hi_ok & (idx == CTRL_IDX);
  assign hit_boot = hi_ok & (idx[15:9] == BOOT_IDX_HI);
  assign cmd_go   = wr_full & hit_cmd;
  assign wr_sba   = wr_full & hit_sba;
  assign wr_boot  = req & i_wb_we & hit_boot;
  assign blk_sel  = sba_q[BLOCK_BITS-1:0];
  assign cur      = prot_q[blk_sel];
  assign nxt      = next_prot(cur, i_wb_dat[15:0]);

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      if (req) begin
        if (hit_cmd) begin
          rdat_q <= {ZERO_WORD, cmd_q};
        end else if (hit_sba) begin
          rdat_q <= {ZERO_WORD, sba_q};
        end else if (hit_wps) begin
          rdat_q <= {ZERO_WORD, WPS_PAD, wps_q};
        end else if (hit_ctrl) begin
          rdat_q <= {ZERO_WORD, CTRL_PAD, werr_q, boot_q == BOOT_DONE};
        end else if (hit_boot) begin
          rdat_q <= {ZERO_WORD, boot_mem[idx[8:0]]};
        end else begin
          rdat_q <= 32'h0000_0000;
        end
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ----------------------------------------------------------------
  // command and start block registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_q <= REG_RESET;
      sba_q <= REG_RESET;
    end else if (warm) begin
      cmd_q <= REG_RESET;
      sba_q <= REG_RESET;
    end else if (cmd_go && i_wb_dat[15:0] == CMD_HOT_RESET) begin
      cmd_q <= REG_RESET;
      sba_q <= REG_RESET;
    end else if (cmd_go) begin
      cmd_q <= i_wb_dat[15:0];
    end else if (wr_sba) begin
      sba_q <= i_wb_dat[15:0];
    end
  end

  // ----------------------------------------------------------------
  // per-block protection states
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        prot_q[b] <= PROT_LOCKED;
      end
    end else if (warm) begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        prot_q[b] <= PROT_LOCKED;
      end
    end else if (cmd_go) begin
      prot_q[blk_sel] <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // protection status
  // ----------------------------------------------------------------
  // kept on hot reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wps_q <= WPS_LOCKED;
    end else if (warm) begin
      wps_q <= WPS_LOCKED;
    end else if (cmd_go && (i_wb_dat[15:0] == CMD_UNLOCK || i_wb_dat[15:0] == CMD_LOCK ||
                            i_wb_dat[15:0] == CMD_LOCK_TIGHT)) begin
      wps_q <= wps_code(nxt);
    end else if (wr_sba) begin
      wps_q <= wps_code(prot_q[i_wb_dat[BLOCK_BITS-1:0]]);
    end
  end

  // ----------------------------------------------------------------
  // program and erase permission
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_done_q  <= 1'b0;
      op_allow_q <= 1'b0;
    end else begin
      op_done_q <= i_op.valid;
      if (i_op.valid) begin
        op_allow_q <= (prot_q[i_op.block] == PROT_UNLOCKED);
      end
    end
  end

  assign o_op_done  = op_done_q;
  assign o_op_allow = op_allow_q;

  // ----------------------------------------------------------------
  // boot copy
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_q      <= BOOT_IDLE;
      boot_addr_q <= BOOT_FIRST;
    end else begin
      case (boot_q)
        BOOT_IDLE: begin
          boot_q <= BOOT_COPY;
        end
        BOOT_COPY: begin
          if (i_boot_rd.valid) begin
            if (boot_addr_q == BOOT_LAST) begin
              boot_q <= BOOT_DONE;
            end else begin
              boot_addr_q <= boot_addr_q + 9'h001;
            end
          end
        end
        BOOT_DONE: begin
          boot_q <= BOOT_DONE;
        end
        default: begin
          boot_q <= BOOT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (boot_q == BOOT_COPY && i_boot_rd.valid) begin
      boot_mem[boot_addr_q] <= i_boot_rd.data;
    end
  end

  assign o_boot_rd.req  = (boot_q == BOOT_COPY);
  assign o_boot_rd.addr = boot_addr_q;
  assign o_boot_done    = (boot_q == BOOT_DONE);

  // ----------------------------------------------------------------
  // boot buffer write refusal flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      werr_q <= 1'b0;
    end else if (wr_boot) begin
      werr_q <= 1'b1;
    end else if (wr_full && hit_ctrl && i_wb_dat[CTRL_WERR_BIT]) begin
      werr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic [WORD_W-1:0] boot_word0;
  assign boot_word0 = boot_mem[idx[8:0]];

  sequence copy_last_s;
    boot_q == BOOT_COPY && i_boot_rd.valid && boot_addr_q == BOOT_LAST;
  endsequence

  sequence locked_unlock_s;
    cmd_go && !warm && i_wb_dat[15:0] == CMD_UNLOCK && cur == PROT_LOCKED;
  endsequence

  boot_copy_end_a: assert property (copy_last_s |=> o_boot_done ##1 o_boot_done)
    else $error("boot copy did not finish after last word");

  boot_lock_a: assert property (
    (o_boot_done && wr_boot) |=> (werr_q && $stable(boot_word0)))
    else $error("boot buffer write not refused");

  warm_lock_a: assert property (warm |=> (prot_q[$past(blk_sel)] == PROT_LOCKED &&
                                         wps_q == WPS_LOCKED))
    else $error("warm reset left a block or status unlocked");

  unlock_one_a: assert property (locked_unlock_s |=>
    (prot_q[$past(blk_sel)] == PROT_UNLOCKED && wps_q == WPS_UNLOCKED))
    else $error("unlock did not release addressed block");

  relock_a: assert property ((cmd_go && !warm && i_wb_dat[15:0] == CMD_LOCK &&
                              cur == PROT_UNLOCKED) |=> prot_q[$past(blk_sel)] == PROT_LOCKED)
    else $error("lock did not relock unlocked block");

  tight_needs_lock_a: assert property ((cmd_go && !warm &&
    i_wb_dat[15:0] == CMD_LOCK_TIGHT) |=>
    (prot_q[$past(blk_sel)] == ($past(cur) == PROT_LOCKED ? PROT_TIGHT : $past(cur))))
    else $error("lock-tight applied to block not locked");

  tight_hold_a: assert property ((cmd_go && !warm && cur == PROT_TIGHT) |=>
                                 prot_q[$past(blk_sel)] == PROT_TIGHT)
    else $error("locked-tight block changed by command");

  op_gate_a: assert property (i_op.valid |=> (o_op_done &&
    o_op_allow == ($past(prot_q[i_op.block]) == PROT_UNLOCKED)))
    else $error("program or erase permission wrong");

  hot_keep_a: assert property ((cmd_go && !warm &&
    (i_wb_dat[15:0] == CMD_HOT_RESET || i_wb_dat[15:0] == CMD_CORE_RESET)) |=>
    ($stable(wps_q) && prot_q[$past(blk_sel)] == $past(cur)))
    else $error("hot or core reset disturbed protection");

  sba_refresh_a: assert property ((wr_sba && !warm) |=>
    (wps_q == wps_code(prot_q[sba_q[BLOCK_BITS-1:0]])))
    else $error("status not refreshed on block number write");

  hot_clear_a: assert property ((cmd_go && !warm && i_wb_dat[15:0] == CMD_HOT_RESET) |=>
                                (cmd_q == REG_RESET && sba_q == REG_RESET))
    else $error("hot reset did not clear registers");

endmodule

`default_nettype wire

// [test/boot_flash_model.sv]
// flash word supplier for the power-up boot copy, answering with random delay
`timescale 1ns/1ps
`default_nettype none
module boot_flash_model (
  input  wire logic                            i_clk,
  input  wire flash_protect_pkg::boot_rd_req_t i_req,
  output flash_protect_pkg::boot_rd_rsp_t      o_rsp
);
  import flash_protect_pkg::*;
  int unsigned wait_q;
  initial begin
    o_rsp  = '0;
    wait_q = 0;
  end
  // one word per request, 1..3 idle cycles before each word after the first; idle data toggles each cycle
  always @(posedge i_clk) begin
    if (i_req.req && !o_rsp.valid && wait_q == 0) begin
      o_rsp.valid <= 1'b1;
      o_rsp.data  <= {7'h35, i_req.addr} ^ 16'h0c0c;
      wait_q      <= $urandom_range(2, 0);
    end else begin
      o_rsp.valid <= 1'b0;
      o_rsp.data  <= ~o_rsp.data;
      if (i_req.req && !o_rsp.valid) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb_flash_block_write_protect.sv]
// self-checking bench for the block write-protect logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_flash_block_write_protect;
  import flash_protect_pkg::*;
  localparam logic [31:0] A_CMD = 32'h0003c880;
  localparam logic [31:0] A_SBA = 32'h0003c930;
  localparam logic [31:0] A_WPS = 32'h0003c938;
  localparam logic [31:0] A_CTL = 32'h0003c940;
  logic         i_clk, i_reset_n, pin_n, cyc, stb, we;
  logic         o_wb_ack, o_op_done, o_op_allow, o_boot_done;
  logic [31:0]  adr, wdat, o_wb_dat, rd;
  logic [3:0]   sel;
  op_req_t      op;
  boot_rd_req_t boot_req;
  boot_rd_rsp_t boot_rsp;
  logic [15:0]  cmds [3] = '{16'h0023, 16'h002a, 16'h002c};
  int           bidx [4] = '{0, 1, 256, 511};
  // one state per block: 0 locked, 1 unlocked, 2 tight
  int           prot [NUM_BLOCKS];
  int           failures, check_count, blk, sba_q, n;

  flash_block_write_protect flash_block_write_protect_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_hw_reset_pin_n(pin_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_op(op), .o_op_done(o_op_done), .o_op_allow(o_op_allow),
    .o_boot_rd(boot_req), .i_boot_rd(boot_rsp), .o_boot_done(o_boot_done));
  boot_flash_model boot_flash_model_inst (
    .i_clk(i_clk), .i_req(boot_req), .o_rsp(boot_rsp));

  always #4 i_clk = ~i_clk;

  function automatic logic [15:0] bword(input int i);
    return {7'h35, i[8:0]} ^ 16'h0c0c;
  endfunction
  function automatic logic [2:0] code(input int s);
    return (s == 1) ? 3'b100 : (s == 2) ? 3'b001 : 3'b010;
  endfunction

  // ----------------------------------------------------------------
  // bus, query and command tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic w);
    @(posedge i_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic status_chk();
    bus(A_WPS, 32'h0, 4'hf, 1'b0);
    `CHK(rd, {29'h0, code(prot[sba_q])});
  endtask
  task automatic query(input int b);
    @(posedge i_clk);
    op <= '{valid: 1'b1, block: b[9:0]};
    @(posedge i_clk);
    op <= '0;
    #1;
    `CHK(o_op_done, 1'b1);
    `CHK(o_op_allow, logic'(prot[b] == 1));
  endtask
  task automatic apply(input int b, input logic [15:0] c);
    case (c)
      16'h0023: if (prot[b] == 0) prot[b] = 1;
      16'h002a: if (prot[b] == 1) prot[b] = 0;
      16'h002c: if (prot[b] == 0) prot[b] = 2;
      default: ;
    endcase
  endtask
  task automatic prot_cmd(input int b, input logic [15:0] c);
    // block number first, one command per block
    bus(A_SBA, 32'(b), 4'h3, 1'b1);
    sba_q = b;
    status_chk();
    bus(A_CMD, {16'h0, c}, 4'h3, 1'b1);
    apply(b, c);
    status_chk();
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    i_clk = 0;
    i_reset_n = 0;
    pin_n = 1;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    wdat = 0;
    sel = 0;
    op = '0;
    failures = 0;
    check_count = 0;
    sba_q = 0;
    foreach (prot[i]) prot[i] = 0;
    void'($urandom(28));
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    n = 0;
    while (o_boot_done !== 1'b1 && n < 5000) begin
      @(posedge i_clk);
      n++;
    end
    `CHK(o_boot_done, 1'b1);
    foreach (bidx[i]) begin
      bus(32'(bidx[i] * 4), 32'h0, 4'hf, 1'b0);
      `CHK(rd, {16'h0, bword(bidx[i])});
    end
    bus(32'h0, 32'h0000ffff, 4'hf, 1'b1);
    bus(32'h0, 32'h0, 4'hf, 1'b0);
    `CHK(rd, {16'h0, bword(0)});
    bus(A_CTL, 32'h0, 4'hf, 1'b0);
    `CHK(rd, 32'h3);
    bus(A_CTL, 32'h2, 4'h3, 1'b1);
    bus(A_CTL, 32'h0, 4'hf, 1'b0);
    `CHK(rd, 32'h1);
    bus(32'h00010000, 32'h0, 4'hf, 1'b0);
    `CHK(rd, 32'h0);
    bus(A_CMD, 32'h23, 4'h1, 1'b1);
    status_chk();
    query(0);
    $display("test boot_and_defaults done");
    prot_cmd(1023, 16'h0023);
    prot_cmd(1023, 16'h002c);
    query(1023);
    query(0);
    repeat (60) begin
      blk = $urandom_range(3, 0);
      if ($urandom_range(4, 0) == 0) blk = $urandom_range(1023, 0);
      prot_cmd(blk, cmds[$urandom_range(2, 0)]);
      query(blk);
      query((blk + 1) % NUM_BLOCKS);
    end
    prot_cmd(2, 16'h002a);
    prot_cmd(2, 16'h002c);
    prot_cmd(2, 16'h0023);
    $display("test commands done");
    bus(A_CMD, 32'h00f3, 4'h3, 1'b1);
    status_chk();
    bus(A_SBA, 32'h0, 4'hf, 1'b0);
    `CHK(rd, 32'h0);
    bus(32'h8, 32'h0, 4'hf, 1'b0);
    `CHK(rd, {16'h0, bword(2)});
    bus(A_CMD, 32'h00f0, 4'h3, 1'b1);
    status_chk();
    for (int b = 0; b < 4; b++) query(b);
    bus(A_CMD, 32'h002c, 4'h3, 1'b1);
    apply(0, 16'h002c);
    sba_q = 0;
    status_chk();
    $display("test hot_reset done");
    pin_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    foreach (prot[i]) prot[i] = 0;
    status_chk();
    for (int b = 0; b < 4; b++) query(b);
    query(1023);
    prot_cmd(2, 16'h0023);
    query(2);
    `CHK(o_boot_done, 1'b1);
    bus(32'h4, 32'h0, 4'hf, 1'b0);
    `CHK(rd, {16'h0, bword(1)});
    $display("test warm_reset done");
    finish_test();
  end

  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
